/* File: core/ebcs_pkg.sv */
// shared constants and types of the external bus cycle signalling block
package ebcs_pkg;

  // ----------------------------------------------------------------
  // bus cycle status codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ST_INT_ACK   = 3'h0;
  localparam logic [2:0] ST_IO_READ   = 3'h1;
  localparam logic [2:0] ST_IO_WRITE  = 3'h2;
  localparam logic [2:0] ST_HALT      = 3'h3;
  localparam logic [2:0] ST_FETCH     = 3'h4;
  localparam logic [2:0] ST_MEM_READ  = 3'h5;
  localparam logic [2:0] ST_MEM_WRITE = 3'h6;
  localparam logic [2:0] ST_PASSIVE   = 3'h7;

  // ----------------------------------------------------------------
  // upper memory window
  // ----------------------------------------------------------------
  localparam logic [19:0] UCS_RESET_START = 20'hF0000;
  localparam logic [19:0] UCS_MIN_START   = 20'h80000;
  localparam logic [19:0] RESET_ENTRY     = 20'hFFFF0;

  // ----------------------------------------------------------------
  // bus phase sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_T1    = 3'b001,
    PH_T2    = 3'b010,
    PH_T3    = 3'b011,
    PH_TW    = 3'b100,
    PH_T4    = 3'b101,
    PH_HOLD  = 3'b110,
    PH_FLOAT = 3'b111
  } ebcs_phase_e;

endpackage

/* File: core/ebcs_bus_signaling.sv */
// bus cycle sequencer with status, strobes, chip select and strap capture
`timescale 1ns/1ps
`default_nettype none

// How it works
// - status pins carry the 3-bit cycle code; 111 means passive
// - status pins float in bus hold
// - dma flag high in phases two to four of dma cycles
// - dma flag floats in bus hold and during reset
// - lock output low only in first phase of a locked cycle
// - half clock strap low at reset release selects pll bypass, clock/2
// - sync ready marks cycle completion; low leaves it to async ready
// - upper select for the programmable top block, up to 512 Kbytes, high in hold
// - after reset the upper block is F0000h to FFFFFh
// - both emulation straps low at reset release floats all pins
// - emulation strap 1 pullup only during reset; pin kept in hold
// - upper zero flag low for whole cycle when top address nibble is zero
// - write upper byte is upper enable ORed with write strobe
// - write lower byte is address bit 0 ORed with write strobe
// - 8-bit variant byte write strobe on every write, early timing
// - write strobe low for writes; floats in hold or reset
module ebcs_bus_signaling
  import ebcs_pkg::*;
#(
  parameter bit DATA16 = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        reset_pin_n,
  input  wire logic        half_clock_strap,
  input  wire logic        emulation_strap_1,
  input  wire logic        emulation_strap_0,
  input  wire logic        hold_req,
  input  wire logic        async_ready_in,
  input  wire logic        sync_ready_in,
  input  wire logic        req_valid,
  input  wire logic [2:0]  req_type,
  input  wire logic [19:0] req_addr,
  input  wire logic        req_dma,
  input  wire logic        req_lock,
  input  wire logic        req_upper_byte_n,
  input  wire logic        ucs_load,
  input  wire logic [19:0] ucs_load_start,
  output logic             req_taken,
  output logic             cycle_done,
  output logic             hold_ack,
  output logic [2:0]       bus_cycle_status,
  output logic             bus_cycle_status_oe_n,
  output logic             dma_cycle_flag,
  output logic             dma_cycle_flag_oe_n,
  output logic             bus_lock_out_n,
  output logic             bus_lock_out_oe_n,
  output logic             upper_mem_select_n,
  output logic             upper_mem_select_oe_n,
  output logic             top_nibble_zero_flag_n,
  output logic             top_nibble_zero_flag_oe_n,
  output logic             write_strobe_out_n,
  output logic             write_strobe_out_oe_n,
  output logic             write_upper_byte_n,
  output logic             write_upper_byte_oe_n,
  output logic             write_lower_byte_n,
  output logic             write_lower_byte_oe_n,
  output logic             byte_write_strobe_n,
  output logic             byte_write_strobe_oe_n,
  output logic             strap1_pullup_en,
  output logic             pll_bypass,
  output logic             all_pins_float_mode
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_pin_sync_reg;
  logic [1:0] clk2_sync_reg;
  logic [1:0] emu1_sync_reg;
  logic [1:0] emu0_sync_reg;
  logic [1:0] hold_sync_reg;
  logic [1:0] ardy_sync_reg;
  logic       rst_pin_prev_reg;

  always_ff @(posedge sys_clk)
  begin
    rst_pin_sync_reg <= {rst_pin_sync_reg[0], reset_pin_n};
    clk2_sync_reg    <= {clk2_sync_reg[0], half_clock_strap};
    emu1_sync_reg    <= {emu1_sync_reg[0], emulation_strap_1};
    emu0_sync_reg    <= {emu0_sync_reg[0], emulation_strap_0};
    hold_sync_reg    <= {hold_sync_reg[0], hold_req};
    ardy_sync_reg    <= {ardy_sync_reg[0], async_ready_in};
    rst_pin_prev_reg <= rst_pin_sync_reg[1];
  end

  // ----------------------------------------------------------------
  // reset view and strap capture
  // ----------------------------------------------------------------
  wire in_reset   = srst | ~rst_pin_sync_reg[1];
  wire rst_rise   = rst_pin_sync_reg[1] & ~rst_pin_prev_reg;
  wire hold_s     = hold_sync_reg[1];
  wire ready_any  = sync_ready_in | ardy_sync_reg[1];

  logic pll_bypass_reg;
  logic float_mode_reg;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pll_bypass_reg <= 1'b0;
      float_mode_reg <= 1'b0;
    end
    else if (rst_rise)
    begin
      pll_bypass_reg <= ~clk2_sync_reg[1];
      float_mode_reg <= ~emu1_sync_reg[1] & ~emu0_sync_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // upper block start address
  // ----------------------------------------------------------------
  logic [19:0] ucs_start_reg;
  wire         ucs_load_ok = ucs_load & (ucs_load_start >= UCS_MIN_START);

  always_ff @(posedge sys_clk)
  begin
    if (in_reset)
      ucs_start_reg <= UCS_RESET_START;
    else if (ucs_load_ok)
      ucs_start_reg <= ucs_load_start;
  end

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  ebcs_phase_e state_reg;
  ebcs_phase_e state_next;
  logic [2:0]  cyc_type_reg;
  logic [19:0] cyc_addr_reg;
  logic        cyc_dma_reg;
  logic        cyc_lock_reg;
  logic        cyc_ube_n_reg;

  wire take = (state_reg == PH_IDLE) & req_valid & ~hold_s & ~float_mode_reg;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      PH_IDLE:
        if (float_mode_reg)
          state_next = PH_FLOAT;
        else if (hold_s)
          state_next = PH_HOLD;
        else if (req_valid)
          state_next = PH_T1;
      PH_T1:    state_next = PH_T2;
      PH_T2:    state_next = PH_T3;
      PH_T3:    state_next = ready_any ? PH_T4 : PH_TW;
      PH_TW:    state_next = ready_any ? PH_T4 : PH_TW;
      PH_T4:    state_next = PH_IDLE;
      PH_HOLD:  state_next = hold_s ? PH_HOLD : PH_IDLE;
      PH_FLOAT: state_next = PH_FLOAT;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (in_reset)
      state_reg <= PH_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge sys_clk)
  begin
    if (take)
    begin
      cyc_type_reg  <= req_type;
      cyc_addr_reg  <= req_addr;
      cyc_dma_reg   <= req_dma;
      cyc_lock_reg  <= req_lock;
      cyc_ube_n_reg <= req_upper_byte_n;
    end
  end

  // ----------------------------------------------------------------
  // pin value decode
  // ----------------------------------------------------------------
  wire in_cycle  = (state_reg == PH_T1) | (state_reg == PH_T2) | (state_reg == PH_T3)
                 | (state_reg == PH_TW) | (state_reg == PH_T4);
  wire late_ph   = (state_reg == PH_T2) | (state_reg == PH_T3) | (state_reg == PH_TW);
  wire is_hold   = state_reg == PH_HOLD;
  wire is_float  = float_mode_reg;
  wire is_write  = (cyc_type_reg == ST_IO_WRITE) | (cyc_type_reg == ST_MEM_WRITE);
  wire is_mem    = cyc_type_reg[2] & (cyc_type_reg != ST_PASSIVE);
  wire in_upper  = cyc_addr_reg >= ucs_start_reg;

  wire [2:0] status_next = (in_cycle & (state_reg != PH_T4)) ? cyc_type_reg
                                                              : ST_PASSIVE;
  wire dma_next   = (late_ph | (state_reg == PH_T4)) & cyc_dma_reg;
  wire lock_next  = ~((state_reg == PH_T1) & cyc_lock_reg);
  wire ucs_next   = ~(in_cycle & is_mem & in_upper) | is_hold;
  wire uzi_next   = ~(in_cycle & (cyc_addr_reg[19:16] == 4'h0));
  wire wr_next    = ~(late_ph & is_write);
  wire whb_next   = cyc_ube_n_reg | wr_next;
  wire wlb_next   = cyc_addr_reg[0] | wr_next;
  wire wb_next    = ~((state_reg != PH_T4) & in_cycle & is_write);

  wire float_status = is_hold | in_reset | is_float;
  wire float_dma    = is_hold | in_reset | is_float;
  wire float_wr     = is_hold | in_reset | is_float;
  wire float_bytes  = in_reset | is_float;

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  logic [2:0] status_reg;
  logic       status_oe_n_reg;
  logic       dma_reg;
  logic       dma_oe_n_reg;
  logic       lock_n_reg;
  logic       ucs_n_reg;
  logic       uzi_n_reg;
  logic       wr_n_reg;
  logic       wr_oe_n_reg;
  logic       whb_n_reg;
  logic       wlb_n_reg;
  logic       wb_n_reg;
  logic       bytes_oe_n_reg;
  logic       pins_oe_n_reg;
  logic       pullup_reg;
  logic       taken_reg;
  logic       done_reg;
  logic       hold_ack_reg;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      status_reg      <= ST_PASSIVE;
      status_oe_n_reg <= 1'b1;
      dma_reg         <= 1'b0;
      dma_oe_n_reg    <= 1'b1;
      lock_n_reg      <= 1'b1;
      ucs_n_reg       <= 1'b1;
      uzi_n_reg       <= 1'b1;
      wr_n_reg        <= 1'b1;
      wr_oe_n_reg     <= 1'b1;
      whb_n_reg       <= 1'b1;
      wlb_n_reg       <= 1'b1;
      wb_n_reg        <= 1'b1;
      bytes_oe_n_reg  <= 1'b1;
      pins_oe_n_reg   <= 1'b0;
      pullup_reg      <= 1'b1;
      taken_reg       <= 1'b0;
      done_reg        <= 1'b0;
      hold_ack_reg    <= 1'b0;
    end
    else
    begin
      status_reg      <= status_next;
      status_oe_n_reg <= float_status;
      dma_reg         <= dma_next;
      dma_oe_n_reg    <= float_dma;
      lock_n_reg      <= lock_next;
      ucs_n_reg       <= ucs_next;
      uzi_n_reg       <= uzi_next;
      wr_n_reg        <= wr_next;
      wr_oe_n_reg     <= float_wr;
      whb_n_reg       <= whb_next;
      wlb_n_reg       <= wlb_next;
      wb_n_reg        <= wb_next;
      bytes_oe_n_reg  <= float_bytes;
      pins_oe_n_reg   <= is_float;
      pullup_reg      <= in_reset;
      taken_reg       <= take & ~in_reset;
      done_reg        <= (state_reg == PH_T4) & ~in_reset;
      hold_ack_reg    <= is_hold & ~in_reset;
    end
  end

  // ----------------------------------------------------------------
  // port drive
  // ----------------------------------------------------------------
  assign req_taken                 = taken_reg;
  assign cycle_done                = done_reg;
  assign hold_ack                  = hold_ack_reg;
  assign bus_cycle_status          = status_reg;
  assign bus_cycle_status_oe_n     = status_oe_n_reg;
  assign dma_cycle_flag            = dma_reg;
  assign dma_cycle_flag_oe_n       = dma_oe_n_reg;
  assign bus_lock_out_n            = lock_n_reg;
  assign bus_lock_out_oe_n         = pins_oe_n_reg;
  assign upper_mem_select_n        = ucs_n_reg;
  assign upper_mem_select_oe_n     = pins_oe_n_reg;
  assign top_nibble_zero_flag_n    = uzi_n_reg;
  assign top_nibble_zero_flag_oe_n = pins_oe_n_reg;
  assign write_strobe_out_n        = wr_n_reg;
  assign write_strobe_out_oe_n     = wr_oe_n_reg;
  assign write_upper_byte_n        = DATA16 ? whb_n_reg : 1'b1;
  assign write_upper_byte_oe_n     = DATA16 ? bytes_oe_n_reg : 1'b1;
  assign write_lower_byte_n        = DATA16 ? wlb_n_reg : 1'b1;
  assign write_lower_byte_oe_n     = DATA16 ? bytes_oe_n_reg : 1'b1;
  assign byte_write_strobe_n       = DATA16 ? 1'b1 : wb_n_reg;
  assign byte_write_strobe_oe_n    = DATA16 ? 1'b1 : bytes_oe_n_reg;
  assign strap1_pullup_en          = pullup_reg;
  assign pll_bypass                = pll_bypass_reg;
  assign all_pins_float_mode       = float_mode_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_status_code: assert property (
    @(posedge sys_clk) disable iff (srst)
    (state_reg == PH_T1) && !in_reset |=> ##1 bus_cycle_status == cyc_type_reg)
    else $error("status code differs from cycle type");

  a_status_hold: assert property (
    @(posedge sys_clk) disable iff (srst)
    is_hold |=> bus_cycle_status_oe_n)
    else $error("status driven in bus hold");

  a_dma_phase: assert property (
    @(posedge sys_clk) disable iff (srst)
    (state_reg == PH_T1) && cyc_dma_reg && !in_reset
    |=> ##2 dma_cycle_flag[*2])
    else $error("dma flag missing in late phases");

  a_dma_float: assert property (
    @(posedge sys_clk) disable iff (srst)
    in_reset |=> dma_cycle_flag_oe_n)
    else $error("dma flag driven in reset");

  a_lock_first: assert property (
    @(posedge sys_clk) disable iff (srst)
    !bus_lock_out_n |-> $past(state_reg) == PH_T1)
    else $error("lock low outside first phase");

  a_ucs_hold: assert property (
    @(posedge sys_clk) disable iff (srst)
    is_hold |=> upper_mem_select_n)
    else $error("upper select low in hold");

  a_ucs_reset: assert property (
    @(posedge sys_clk) disable iff (srst)
    in_reset |=> (ucs_start_reg == UCS_RESET_START) && (RESET_ENTRY >= ucs_start_reg))
    else $error("upper block not reset to top 64K");

  a_uzi_cycle: assert property (
    @(posedge sys_clk) disable iff (srst)
    (state_reg == PH_T1) && (cyc_addr_reg[19:16] == 4'h0) && !in_reset
    |=> ##1 !top_nibble_zero_flag_n[*3])
    else $error("upper zero flag not held");

  a_whb_or: assert property (
    @(posedge sys_clk) disable iff (srst)
    DATA16 && !write_upper_byte_n |-> !write_strobe_out_n)
    else $error("upper byte write without write strobe");

  a_wr_float: assert property (
    @(posedge sys_clk) disable iff (srst)
    (in_reset || is_hold) |=> write_strobe_out_oe_n)
    else $error("write strobe driven in hold or reset");

  a_wait_state: assert property (
    @(posedge sys_clk) disable iff (srst)
    (state_reg == PH_T3) && !ready_any && !in_reset |=> state_reg == PH_TW)
    else $error("no wait state while not ready");

endmodule // ebcs_bus_signaling

`default_nettype wire

/* File: tb/ebcs_mem_model.sv */
// memory and io device model that answers bus cycles on the synchronous ready line
`timescale 1ns/1ps
`default_nettype none
module ebcs_mem_model
  import ebcs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [2:0] bus_cycle_status,
  input  wire logic       bus_cycle_status_oe_n,
  input  wire logic [7:0] wait_cycles,
  output logic            sync_ready_in
);
  // ----------------------------------------------------------------
  // wait counter, loaded when a cycle shows on the status pins
  // ----------------------------------------------------------------
  logic [7:0] cnt_reg  = 8'h00;
  logic       busy_reg = 1'b0;
  wire        active   = !bus_cycle_status_oe_n && (bus_cycle_status != ST_PASSIVE);
  wire        start    = active && !busy_reg;
  always_ff @(posedge sys_clk)
  begin
    busy_reg <= active;
    if (start)
      cnt_reg <= wait_cycles;
    else if (cnt_reg != 8'h00)
      cnt_reg <= cnt_reg - 8'h01;
  end
  assign sync_ready_in = (cnt_reg == 8'h00) && !start;
endmodule // ebcs_mem_model
`default_nettype wire

/* File: tb/ebcs_bus_signaling_tb.sv */
// self-checking bench of the bus cycle signalling block
`timescale 1ns/1ps
`default_nettype none
module ebcs_bus_signaling_tb;
  import ebcs_pkg::*;
  typedef struct packed {
    logic [2:0] t; logic [19:0] a; logic d; logic l; logic u; logic ucs_n; logic uzi_n;
  } ebcs_row_s;
  logic sys_clk = 1'b0, srst = 1'b1, reset_pin_n = 1'b1, half_clock_strap = 1'b1;
  logic emulation_strap_1 = 1'b1, emulation_strap_0 = 1'b1, hold_req = 1'b0;
  logic async_ready_in = 1'b0, sync_ready_in, req_valid = 1'b0, req_dma = 1'b0;
  logic req_lock = 1'b0, req_upper_byte_n = 1'b1, ucs_load = 1'b0;
  logic [2:0]  req_type = 3'h0, bus_cycle_status;
  logic [19:0] req_addr = 20'h00000, ucs_load_start = 20'h00000;
  logic [7:0]  wait_cycles = 8'h00;
  logic req_taken, cycle_done, hold_ack, bus_cycle_status_oe_n, dma_cycle_flag;
  logic dma_cycle_flag_oe_n, bus_lock_out_n, bus_lock_out_oe_n, upper_mem_select_n;
  logic upper_mem_select_oe_n, top_nibble_zero_flag_n, top_nibble_zero_flag_oe_n;
  logic write_strobe_out_n, write_strobe_out_oe_n, write_upper_byte_n, write_upper_byte_oe_n;
  logic write_lower_byte_n, write_lower_byte_oe_n, byte_write_strobe_n, byte_write_strobe_oe_n;
  logic strap1_pullup_en, pll_bypass, all_pins_float_mode, tk, w;
  logic [5:0] p1;
  logic [3:0] p2;
  int err_count = 0, n_tests = 0, len = 0, l1 = 0;
  ebcs_row_s rows [8] = '{
    '{ST_INT_ACK,   20'h00000, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0},
    '{ST_IO_READ,   20'h00100, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0},
    '{ST_IO_WRITE,  20'h00201, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0},
    '{ST_HALT,      20'h10000, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1},
    '{ST_FETCH,     20'hFFFF0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1},
    '{ST_MEM_READ,  20'hF0000, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1},
    '{ST_MEM_WRITE, 20'hEFFFE, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1},
    '{ST_MEM_WRITE, 20'hFFFFF, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1}};
  always #4 sys_clk = ~sys_clk;
  ebcs_bus_signaling u_dut (
    .sys_clk(sys_clk), .srst(srst), .reset_pin_n(reset_pin_n),
    .half_clock_strap(half_clock_strap), .emulation_strap_1(emulation_strap_1),
    .emulation_strap_0(emulation_strap_0), .hold_req(hold_req), .async_ready_in(async_ready_in),
    .sync_ready_in(sync_ready_in), .req_valid(req_valid), .req_type(req_type),
    .req_addr(req_addr), .req_dma(req_dma), .req_lock(req_lock),
    .req_upper_byte_n(req_upper_byte_n), .ucs_load(ucs_load), .ucs_load_start(ucs_load_start),
    .req_taken(req_taken), .cycle_done(cycle_done), .hold_ack(hold_ack),
    .bus_cycle_status(bus_cycle_status), .bus_cycle_status_oe_n(bus_cycle_status_oe_n),
    .dma_cycle_flag(dma_cycle_flag), .dma_cycle_flag_oe_n(dma_cycle_flag_oe_n),
    .bus_lock_out_n(bus_lock_out_n), .bus_lock_out_oe_n(bus_lock_out_oe_n),
    .upper_mem_select_n(upper_mem_select_n), .upper_mem_select_oe_n(upper_mem_select_oe_n),
    .top_nibble_zero_flag_n(top_nibble_zero_flag_n),
    .top_nibble_zero_flag_oe_n(top_nibble_zero_flag_oe_n),
    .write_strobe_out_n(write_strobe_out_n), .write_strobe_out_oe_n(write_strobe_out_oe_n),
    .write_upper_byte_n(write_upper_byte_n), .write_upper_byte_oe_n(write_upper_byte_oe_n),
    .write_lower_byte_n(write_lower_byte_n), .write_lower_byte_oe_n(write_lower_byte_oe_n),
    .byte_write_strobe_n(byte_write_strobe_n), .byte_write_strobe_oe_n(byte_write_strobe_oe_n),
    .strap1_pullup_en(strap1_pullup_en), .pll_bypass(pll_bypass),
    .all_pins_float_mode(all_pins_float_mode));
  ebcs_mem_model u_mem (
    .sys_clk(sys_clk), .bus_cycle_status(bus_cycle_status),
    .bus_cycle_status_oe_n(bus_cycle_status_oe_n), .wait_cycles(wait_cycles),
    .sync_ready_in(sync_ready_in));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one whole bus cycle; p1 holds first-phase pins, p2 second-phase pins
  task automatic run_cycle(input logic [2:0] t, input logic [19:0] a, input logic d, l, u);
    logic seen, drop;
    seen = 1'b0;
    drop = 1'b0;
    len = 0;
    @(posedge sys_clk);
    req_type <= t; req_addr <= a; req_dma <= d; req_lock <= l;
    req_upper_byte_n <= u; req_valid <= 1'b1;
    @(negedge sys_clk);
    for (int k = 0; k < 60 && cycle_done !== 1'b1; k++)
    begin
      @(posedge sys_clk);
      if (drop) req_valid <= 1'b0;
      @(negedge sys_clk);
      drop = (req_taken === 1'b1);
      if (seen) len++;
      if (seen && len == 1)
        p2 = {dma_cycle_flag, write_strobe_out_n, write_upper_byte_n, write_lower_byte_n};
      if (!seen && bus_cycle_status_oe_n === 1'b0 && bus_cycle_status !== ST_PASSIVE)
      begin
        seen = 1'b1;
        p1 = {bus_cycle_status, bus_lock_out_n, upper_mem_select_n, top_nibble_zero_flag_n};
      end
    end
    chk(cycle_done, 1'b1);
  endtask
  task automatic pin_reset(input logic h, e1, e0);
    @(posedge sys_clk);
    half_clock_strap <= h; emulation_strap_1 <= e1; emulation_strap_0 <= e0;
    reset_pin_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(strap1_pullup_en, 1'b1);
    chk({dma_cycle_flag_oe_n, write_strobe_out_oe_n, write_upper_byte_oe_n,
         write_lower_byte_oe_n}, 4'hF);
    @(posedge sys_clk) reset_pin_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    half_clock_strap <= 1'b1; emulation_strap_1 <= 1'b1; emulation_strap_0 <= 1'b1;
    @(negedge sys_clk);
    chk(strap1_pullup_en, 1'b0);
  endtask
  task automatic ucs_set(input logic [19:0] v);
    @(posedge sys_clk);
    ucs_load <= 1'b1;
    ucs_load_start <= v;
    @(posedge sys_clk) ucs_load <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    @(negedge sys_clk);
    chk({bus_cycle_status, bus_cycle_status_oe_n, dma_cycle_flag_oe_n}, 5'h1F);
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    foreach (rows[i])
    begin
      run_cycle(rows[i].t, rows[i].a, rows[i].d, rows[i].l, rows[i].u);
      w = (rows[i].t == ST_IO_WRITE) || (rows[i].t == ST_MEM_WRITE);
      chk(p1, {rows[i].t, !rows[i].l, rows[i].ucs_n, rows[i].uzi_n});
      chk(p2, {rows[i].d, !w, rows[i].u | !w, rows[i].a[0] | !w});
      chk(24'(len), 24'h3);
      chk(bus_cycle_status, ST_PASSIVE);
    end
    wait_cycles = 8'h01;
    run_cycle(ST_MEM_READ, 20'h00000, 1'b0, 1'b0, 1'b1);
    l1 = len;
    wait_cycles = 8'h05;
    run_cycle(ST_MEM_READ, 20'h00000, 1'b0, 1'b0, 1'b1);
    chk(24'(len - l1), 24'h4);
    wait_cycles = 8'h64;
    @(posedge sys_clk) async_ready_in <= 1'b1;
    run_cycle(ST_IO_READ, 20'h00000, 1'b0, 1'b0, 1'b1);
    chk(24'(len < 10), 24'h1);
    @(posedge sys_clk) async_ready_in <= 1'b0;
    repeat (110) @(posedge sys_clk);
    wait_cycles = 8'h00;
    ucs_set(20'h80000);
    run_cycle(ST_MEM_READ, 20'h80000, 1'b0, 1'b0, 1'b1);
    chk(p1[1], 1'b0);
    ucs_set(20'h70000);
    run_cycle(ST_MEM_READ, 20'h7FFFF, 1'b0, 1'b0, 1'b1);
    chk(p1[1], 1'b1);
    pin_reset(1'b0, 1'b1, 1'b1);
    chk({pll_bypass, all_pins_float_mode}, 2'h2);
    run_cycle(ST_MEM_READ, 20'h90000, 1'b0, 1'b0, 1'b1);
    chk(p1[1], 1'b1);
    run_cycle(ST_FETCH, RESET_ENTRY, 1'b0, 1'b0, 1'b1);
    chk(p1[1], 1'b0);
    @(posedge sys_clk) hold_req <= 1'b1;
    for (int k = 0; k < 20 && hold_ack !== 1'b1; k++) @(negedge sys_clk);
    chk({bus_cycle_status_oe_n, dma_cycle_flag_oe_n, write_strobe_out_oe_n,
         upper_mem_select_n, upper_mem_select_oe_n}, 5'h1E);
    @(posedge sys_clk) req_valid <= 1'b1;
    tk = 1'b0;
    repeat (8) @(negedge sys_clk) tk = tk | (req_taken !== 1'b0);
    chk(tk, 1'b0);
    @(posedge sys_clk) hold_req <= 1'b0;
    req_valid <= 1'b0;
    run_cycle(ST_MEM_WRITE, 20'hF1234, 1'b0, 1'b0, 1'b0);
    chk(p2[2:0], 3'h0);
    pin_reset(1'b1, 1'b0, 1'b0);
    chk({pll_bypass, all_pins_float_mode, bus_cycle_status_oe_n, upper_mem_select_oe_n,
         top_nibble_zero_flag_oe_n, bus_lock_out_oe_n}, 6'h1F);
    @(posedge sys_clk) srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    chk(all_pins_float_mode, 1'b0);
    end_of_test();
  end
  initial
  begin
    #100000;
    err_count++;
    end_of_test();
  end
endmodule // ebcs_bus_signaling_tb
`default_nettype wire
